/* File: hw/mfpc_pkg.sv */
// Shared constants for the motor fault protection configuration block.
// Assumes a single 200 MHz system clock and a byte-addressed register port.
package mfpc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h50;
  localparam logic [7:0] ADDR_PROT_CFG = 8'h54;
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  localparam logic [7:0] ADDR_MASK = 8'h74;
  localparam logic [7:0] ADDR_ACTIVE = 8'h78;
  localparam logic [7:0] ADDR_CLEAR = 8'h7c;

  // Field positions of the protection register
  localparam int OSPD_EN_BIT = 26;
  localparam int HALL_EN_BIT = 25;
  localparam int NOLOAD_EN_BIT = 24;
  localparam int OSPD_SEL_LSB = 21;
  localparam int NOLOAD_SEL_LSB = 13;
  localparam int UV_SEL_LSB = 5;
  localparam int UV_MODE_BIT = 4;
  localparam int OV_SEL_LSB = 1;
  localparam int OV_MODE_BIT = 0;

  // Field positions of the lock response register
  localparam int RETRY_LSB = 2;
  localparam int LMODE_LSB = 0;

  // Writable bits and reset values
  localparam logic [31:0] PROT_WMASK = 32'hffe3ffff;
  localparam logic [31:0] PROT_RESET = 32'h00000000;
  localparam logic [31:0] LOCK_RESET = 32'h00000000;
  localparam logic [4:0] STS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Event and fault bit positions in status, mask, active and clear
  localparam int EV_OSPD = 0;
  localparam int EV_HALL = 1;
  localparam int EV_NOLOAD = 2;
  localparam int EV_UV = 3;
  localparam int EV_OV = 4;
  localparam int NUM_EV = 5;

  // Thresholds in tenths of a percent of full scale
  localparam logic [11:0] OSPD_BASE_PM = 12'h514;
  localparam logic [11:0] OSPD_STEP_PM = 12'h064;
  localparam logic [11:0] OV_BASE_PM = 12'h258;
  localparam logic [11:0] OV_STEP_PM = 12'h032;
  localparam logic [11:0] OV_MAX_PM = 12'h3e8;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LOCK_LATCH = 2'h0,
    LOCK_RETRY = 2'h1,
    LOCK_REPORT = 2'h2,
    LOCK_OFF = 2'h3
  } mfpc_lock_mode_type;

endpackage : mfpc_pkg

/* File: hw/mfpc_thresh.sv */
// Threshold decode and compare for the motor fault protection block.
// Assumes measurements in tenths of a percent of full scale, same clock.
`timescale 1ns/10ps
module mfpc_thresh
  import mfpc_pkg::*;
(
  input wire logic [31:0] prot_cfg,
  input wire logic [11:0] speed_meas,
  input wire logic [11:0] current_meas,
  input wire logic [11:0] supply_meas,
  output logic ospd_hit,
  output logic noload_hit,
  output logic uv_hit,
  output logic ov_hit
);

  function automatic logic [11:0] noload_thr(input logic [4:0] code);
    logic [11:0] t;
    t = 12'h000;
    case (code)
      5'h00: t = 12'd75;
      5'h01: t = 12'd80;
      5'h02: t = 12'd85;
      5'h03: t = 12'd90;
      5'h04: t = 12'd95;
      5'h05: t = 12'd100;
      5'h06: t = 12'd110;
      5'h07: t = 12'd120;
      5'h08: t = 12'd130;
      5'h09: t = 12'd140;
      5'h0a: t = 12'd150;
      5'h0b: t = 12'd160;
      5'h0c: t = 12'd170;
      5'h0d: t = 12'd180;
      5'h0e: t = 12'd200;
      5'h0f: t = 12'd225;
      5'h10: t = 12'd250;
      5'h11: t = 12'd275;
      5'h12: t = 12'd300;
      5'h13: t = 12'd350;
      5'h14: t = 12'd400;
      5'h15: t = 12'd450;
      5'h16: t = 12'd500;
      5'h17: t = 12'd550;
      5'h18: t = 12'd600;
      5'h19: t = 12'd700;
      5'h1a: t = 12'd750;
      5'h1b: t = 12'd800;
      5'h1c: t = 12'd850;
      5'h1d: t = 12'd900;
      5'h1e: t = 12'd950;
      default: t = 12'd1000;
    endcase
    return t;
  endfunction : noload_thr

  function automatic logic [11:0] uv_thr(input logic [2:0] code);
    logic [11:0] t;
    t = 12'h000;
    case (code)
      3'h1: t = 12'd50;
      3'h2: t = 12'd100;
      3'h3: t = 12'd120;
      3'h4: t = 12'd150;
      3'h5: t = 12'd180;
      3'h6: t = 12'd200;
      3'h7: t = 12'd250;
      default: t = 12'h000;
    endcase
    return t;
  endfunction : uv_thr

  logic [2:0] ospd_code;
  logic [2:0] uv_code;
  logic [2:0] ov_code;
  logic [11:0] ospd_lvl;
  logic [11:0] ov_lvl;

  assign ospd_code = prot_cfg[OSPD_SEL_LSB +: 3];
  assign uv_code = prot_cfg[UV_SEL_LSB +: 3];
  assign ov_code = prot_cfg[OV_SEL_LSB +: 3];

  assign ospd_lvl = 12'(OSPD_BASE_PM + 12'(ospd_code) * OSPD_STEP_PM);
  // supply ceiling, top code full scale
  assign ov_lvl = (ov_code == 3'h7) ? OV_MAX_PM :
                  12'(OV_BASE_PM + 12'(ov_code) * OV_STEP_PM);

  assign ospd_hit = speed_meas > ospd_lvl;
  assign noload_hit = current_meas < noload_thr(prot_cfg[NOLOAD_SEL_LSB +: 5]);
  assign uv_hit = (uv_code != 3'h0) && (supply_meas < uv_thr(uv_code));
  assign ov_hit = supply_meas > ov_lvl;

endmodule : mfpc_thresh

/* File: hw/mfpc_top.sv */
// Motor fault protection configuration registers and fault flags.
// Assumes a one-cycle register port and measurements from the same clock.
`timescale 1ns/10ps

// Function
// - Bit 26 arms overspeed lock detection
// - Bit 25 arms invalid sensor input lock
// - Bit 24 arms open-load lock detection
// - Bits 23-21 pick overspeed level 130-200%
// - Bits 17-13 pick open-load current table
// - Bits 7-5 pick supply floor, 0 none
// - Bit 4 selects latched or auto undervoltage
// - Bits 3-1 pick supply ceiling 60-90%, max
// - Bit 0 selects latched or auto overvoltage
// - Register at 54h, resets to zero
// - Bits 20-18 read zero; other reserved writable
// - Lock mode: latch, retry, report, off
module mfpc_top
  import mfpc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic meas_valid,
  input wire logic [11:0] speed_meas,
  input wire logic [11:0] current_meas,
  input wire logic [11:0] supply_meas,
  input wire logic hall_invalid,
  output logic irq,
  output logic fault_out_n
);

  typedef struct packed {
    logic [31:0] lock_cfg;
    logic [31:0] prot_cfg;
    logic [4:0] sts;
    logic [4:0] mask;
    logic [2:0] lock;
    logic uv;
    logic ov;
    logic [17:0] tick;
    logic [13:0] ms;
    logic [31:0] rdata;
    logic irq;
    logic fault_n;
  } mfpc_state_type;

  localparam mfpc_state_type ST_RESET = '{
    lock_cfg: LOCK_RESET,
    prot_cfg: PROT_RESET,
    sts: STS_RESET,
    mask: MASK_RESET,
    lock: 3'h0,
    uv: 1'b0,
    ov: 1'b0,
    tick: 18'h00000,
    ms: 14'h0000,
    rdata: 32'h00000000,
    irq: 1'b0,
    fault_n: 1'b1
  };

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  mfpc_state_type st_r;
  mfpc_state_type st_nxt;

  logic ospd_hit;
  logic noload_hit;
  logic uv_hit;
  logic ov_hit;
  logic [2:0] lock_hit;
  logic [4:0] ev;
  logic [4:0] clr;
  logic ms_pulse;
  mfpc_lock_mode_type lmode;

  function automatic logic acc(input logic strobe, input logic [7:0] a,
                               input logic [7:0] target);
    return strobe && (a == target);
  endfunction : acc

  // Retry interval in milliseconds
  function automatic logic [13:0] retry_ms(input logic [3:0] code);
    logic [13:0] m;
    m = 14'h0000;
    case (code)
      4'h0: m = 14'd100;
      4'h1: m = 14'd500;
      default: m = 14'(({10'h000, code} - 14'h0001) * 14'd1000);
    endcase
    return m;
  endfunction : retry_ms

  mfpc_thresh u_thresh (
    .prot_cfg(st_r.prot_cfg),
    .speed_meas(speed_meas),
    .current_meas(current_meas),
    .supply_meas(supply_meas),
    .ospd_hit(ospd_hit),
    .noload_hit(noload_hit),
    .uv_hit(uv_hit),
    .ov_hit(ov_hit)
  );

  assign lmode = mfpc_lock_mode_type'(st_r.lock_cfg[LMODE_LSB +: 2]);
  assign ms_pulse = st_r.tick == TICK_LAST;

  assign lock_hit[EV_OSPD] = st_r.prot_cfg[OSPD_EN_BIT] && ospd_hit;
  assign lock_hit[EV_HALL] = st_r.prot_cfg[HALL_EN_BIT] && hall_invalid;
  assign lock_hit[EV_NOLOAD] = st_r.prot_cfg[NOLOAD_EN_BIT] && noload_hit;

  assign clr = acc(reg_wr, reg_addr, ADDR_CLEAR) ? reg_wdata[4:0] : 5'h00;

  always_comb
  begin
    st_nxt = st_r;
    ev = 5'h00;
    st_nxt.rdata = 32'h00000000;
    st_nxt.tick = ms_pulse ? 18'h00000 : 18'(st_r.tick + 18'h00001);

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_LOCK_CFG: st_nxt.lock_cfg = reg_wdata;
        ADDR_PROT_CFG: st_nxt.prot_cfg = reg_wdata & PROT_WMASK;
        ADDR_MASK: st_nxt.mask = reg_wdata[4:0];
        default: st_nxt.mask = st_nxt.mask;
      endcase
    end

    // Retry timer runs only while a retry-mode lock is held
    // automatic clear after interval
    if (lmode == LOCK_RETRY && (|st_r.lock))
    begin
      if (st_r.ms >= retry_ms(st_r.lock_cfg[RETRY_LSB +: 4]))
      begin
        st_nxt.lock = 3'h0;
        st_nxt.ms = 14'h0000;
      end
      else if (ms_pulse)
      begin
        st_nxt.ms = 14'(st_r.ms + 14'h0001);
      end
    end
    else
    begin
      st_nxt.ms = 14'h0000;
    end

    // Software clear first, so a new detection wins
    st_nxt.lock = st_nxt.lock & ~clr[2:0];
    if (clr[EV_UV])
    begin
      st_nxt.uv = 1'b0;
    end
    if (clr[EV_OV])
    begin
      st_nxt.ov = 1'b0;
    end

    if (meas_valid)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (lock_hit[i] && lmode != LOCK_OFF)
        begin
          ev[i] = 1'b1;
          if (lmode != LOCK_REPORT)
          begin
            st_nxt.lock[i] = 1'b1;
          end
        end
      end
      if (uv_hit)
      begin
        st_nxt.uv = 1'b1;
        ev[EV_UV] = !st_r.uv;
      end
      else if (st_r.prot_cfg[UV_MODE_BIT])
      begin
        st_nxt.uv = 1'b0;
      end
      if (ov_hit)
      begin
        st_nxt.ov = 1'b1;
        ev[EV_OV] = !st_r.ov;
      end
      else if (st_r.prot_cfg[OV_MODE_BIT])
      begin
        st_nxt.ov = 1'b0;
      end
    end

    // Read of status clears it; events of this cycle survive
    if (acc(reg_rd, reg_addr, ADDR_STATUS))
    begin
      st_nxt.sts = 5'h00;
    end
    st_nxt.sts = st_nxt.sts | ev;

    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_LOCK_CFG: st_nxt.rdata = st_r.lock_cfg;
        ADDR_PROT_CFG: st_nxt.rdata = st_r.prot_cfg;
        ADDR_STATUS: st_nxt.rdata = {27'h0000000, st_r.sts};
        ADDR_MASK: st_nxt.rdata = {27'h0000000, st_r.mask};
        ADDR_ACTIVE: st_nxt.rdata = {27'h0000000, st_r.ov, st_r.uv,
                                     st_r.lock};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end

    st_nxt.irq = |(st_nxt.sts & st_nxt.mask);
    st_nxt.fault_n = !((|st_nxt.lock) || st_nxt.uv || st_nxt.ov);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_r <= ST_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign fault_out_n = st_r.fault_n;

  a_reset_zero:
    assert property (@(posedge clk_sys)
      srst |=> (st_r.prot_cfg == 32'h00000000) && fault_out_n)
    else $error("protection register not zero after reset");

  a_ospd_disarmed:
    assert property (@(posedge clk_sys) disable iff (srst)
      !st_r.prot_cfg[OSPD_EN_BIT] && !st_r.lock[EV_OSPD]
      |=> !st_r.lock[EV_OSPD])
    else $error("overspeed lock set while disarmed");

  a_hall_disarmed:
    assert property (@(posedge clk_sys) disable iff (srst)
      !st_r.prot_cfg[HALL_EN_BIT] && !st_r.lock[EV_HALL]
      |=> !st_r.lock[EV_HALL])
    else $error("sensor lock set while disarmed");

  a_noload_disarmed:
    assert property (@(posedge clk_sys) disable iff (srst)
      !st_r.prot_cfg[NOLOAD_EN_BIT] && !st_r.lock[EV_NOLOAD]
      |=> !st_r.lock[EV_NOLOAD])
    else $error("open-load lock set while disarmed");

  a_rsvd_read_zero:
    assert property (@(posedge clk_sys) disable iff (srst)
      acc(reg_rd, reg_addr, ADDR_PROT_CFG) |=> reg_rdata[20:18] == 3'h0)
    else $error("reserved read-only bits not zero");

  a_uv_latch_hold:
    assert property (@(posedge clk_sys) disable iff (srst)
      !st_r.prot_cfg[UV_MODE_BIT] && st_r.uv && !clr[EV_UV] |=> st_r.uv)
    else $error("latched undervoltage dropped");

  a_ov_auto_clear:
    assert property (@(posedge clk_sys) disable iff (srst)
      st_r.prot_cfg[OV_MODE_BIT] && meas_valid && !ov_hit |=> !st_r.ov)
    else $error("overvoltage did not auto clear");

  a_fault_pin_low:
    assert property (@(posedge clk_sys) disable iff (srst)
      (|st_r.lock) |-> !fault_out_n)
    else $error("fault output high while lock held");

  a_report_no_lock:
    assert property (@(posedge clk_sys) disable iff (srst)
      lmode == LOCK_REPORT && !(|st_r.lock) |=> !(|st_r.lock))
    else $error("lock held in report-only mode");

  a_status_read_clear:
    assert property (@(posedge clk_sys) disable iff (srst)
      acc(reg_rd, reg_addr, ADDR_STATUS) && ev == 5'h00
      |=> st_r.sts == 5'h00 && !irq)
    else $error("status not cleared by read");

endmodule : mfpc_top

/* File: verif/tb.sv */
// Self-checking bench for the motor fault protection configuration block.
// Assumes one 200 MHz clock; bench drives every port itself at rising edges.
`timescale 1ns/10ps
module tb;
  import mfpc_pkg::*;
  localparam int TICK = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic meas_valid = 1'b0;
  logic [11:0] speed_meas = 12'h000;
  logic [11:0] current_meas = 12'h000;
  logic [11:0] supply_meas = 12'h000;
  logic hall_invalid = 1'b0;
  logic irq;
  logic fault_out_n;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] v;
  logic [11:0] uv_tab [0:7] = '{12'h000, 12'h032, 12'h064, 12'h078, 12'h096,
    12'h0b4, 12'h0c8, 12'h0fa};

  mfpc_top #(.TICK_CYCLES(TICK)) DUT (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .speed_meas(speed_meas), .current_meas(current_meas),
    .supply_meas(supply_meas), .hall_invalid(hall_invalid), .irq(irq),
    .fault_out_n(fault_out_n));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic meas(input logic [11:0] s, input logic [11:0] c,
    input logic [11:0] u, input logic h);
    @(posedge clk_sys);
    meas_valid <= 1'b1;
    speed_meas <= s;
    current_meas <= c;
    supply_meas <= u;
    hall_invalid <= h;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : meas

  task automatic act(input int b, input logic e);
    rd(ADDR_ACTIVE, v);
    chk_bit(v[b], e);
  endtask : act

  // Clears held faults and sticky status before the next case
  task automatic clr_all;
    wr(ADDR_CLEAR, 32'h0000001f);
    rd(ADDR_STATUS, v);
  endtask : clr_all

  task automatic t_reset;
    chk_bit(irq, 1'b0);
    chk_bit(fault_out_n, 1'b1);
    rd(ADDR_PROT_CFG, v);
    chk_word(v, 32'h00000000);
    rd(ADDR_LOCK_CFG, v);
    chk_word(v, 32'h00000000);
    rd(8'h00, v);
    chk_word(v, 32'h00000000);
    wr(ADDR_PROT_CFG, 32'hffffffff);
    wr(8'h00, 32'h00000000);
    rd(ADDR_PROT_CFG, v);
    chk_word(v, 32'hffe3ffff);
    wr(ADDR_PROT_CFG, 32'h00000000);
  endtask : t_reset

  task automatic t_ospd;
    logic [11:0] lvl;
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    act(EV_OSPD, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      lvl = 12'(1300 + 100 * c);
      wr(ADDR_PROT_CFG, 32'h04000000 | (32'(c) << 21));
      meas(lvl, 12'h1f4, 12'h1f4, 1'b0);
      act(EV_OSPD, 1'b0);
      meas(lvl + 12'h001, 12'h1f4, 12'h1f4, 1'b0);
      act(EV_OSPD, 1'b1);
      chk_bit(fault_out_n, 1'b0);
      clr_all();
    end
  endtask : t_ospd

  task automatic t_hall_load;
    wr(ADDR_PROT_CFG, 32'h00000000);
    meas(12'h000, 12'h000, 12'h1f4, 1'b1);
    rd(ADDR_ACTIVE, v);
    chk_word(v, 32'h00000000);
    wr(ADDR_PROT_CFG, 32'h02000000);
    meas(12'h000, 12'h1f4, 12'h1f4, 1'b1);
    act(EV_HALL, 1'b1);
    clr_all();
    wr(ADDR_PROT_CFG, 32'h01000000);
    meas(12'h000, 12'h04b, 12'h1f4, 1'b0);
    act(EV_NOLOAD, 1'b0);
    meas(12'h000, 12'h04a, 12'h1f4, 1'b0);
    act(EV_NOLOAD, 1'b1);
    clr_all();
    wr(ADDR_PROT_CFG, 32'h01000000 | (32'h1f << 13));
    meas(12'h000, 12'h3e7, 12'h1f4, 1'b0);
    act(EV_NOLOAD, 1'b1);
    clr_all();
  endtask : t_hall_load

  task automatic t_uv;
    wr(ADDR_PROT_CFG, 32'h00000010);
    meas(12'h000, 12'h1f4, 12'h000, 1'b0);
    act(EV_UV, 1'b0);
    for (int c = 1; c < 8; c++)
    begin
      wr(ADDR_PROT_CFG, 32'h00000010 | (32'(c) << 5));
      meas(12'h000, 12'h1f4, uv_tab[c] - 12'h001, 1'b0);
      act(EV_UV, 1'b1);
      meas(12'h000, 12'h1f4, uv_tab[c], 1'b0);
      act(EV_UV, 1'b0);
    end
    wr(ADDR_PROT_CFG, 32'h000000e0);
    meas(12'h000, 12'h1f4, 12'h0f9, 1'b0);
    meas(12'h000, 12'h1f4, 12'h1f4, 1'b0);
    act(EV_UV, 1'b1);
    chk_bit(fault_out_n, 1'b0);
    clr_all();
  endtask : t_uv

  task automatic t_ov;
    logic [11:0] lvl;
    for (int c = 0; c < 8; c++)
    begin
      lvl = (c == 7) ? 12'd1000 : 12'(600 + 50 * c);
      wr(ADDR_PROT_CFG, 32'h00000001 | (32'(c) << 1));
      meas(12'h000, 12'h1f4, lvl + 12'h001, 1'b0);
      act(EV_OV, 1'b1);
      meas(12'h000, 12'h1f4, lvl, 1'b0);
      act(EV_OV, 1'b0);
    end
    wr(ADDR_PROT_CFG, 32'h00000000);
    meas(12'h000, 12'h1f4, 12'h259, 1'b0);
    meas(12'h000, 12'h1f4, 12'h1f4, 1'b0);
    act(EV_OV, 1'b1);
    clr_all();
    act(EV_OV, 1'b0);
  endtask : t_ov

  task automatic t_irq_modes;
    int n;
    wr(ADDR_PROT_CFG, 32'h04000000);
    wr(ADDR_MASK, 32'h00000001);
    rd(ADDR_MASK, v);
    chk_word(v, 32'h00000001);
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    chk_bit(irq, 1'b1);
    rd(ADDR_STATUS, v);
    chk_word(v, 32'h00000001);
    @(posedge clk_sys);
    #1;
    chk_bit(irq, 1'b0);
    clr_all();
    wr(ADDR_MASK, 32'h00000000);
    wr(ADDR_LOCK_CFG, 32'h00000002);
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    chk_bit(irq, 1'b0);
    chk_bit(fault_out_n, 1'b1);
    act(EV_OSPD, 1'b0);
    rd(ADDR_STATUS, v);
    chk_word(v, 32'h00000001);
    wr(ADDR_LOCK_CFG, 32'h00000003);
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    rd(ADDR_STATUS, v);
    chk_word(v, 32'h00000000);
    // Retry code 0 is 100 ms; first tick may come early
    wr(ADDR_LOCK_CFG, 32'h00000001);
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    chk_bit(fault_out_n, 1'b0);
    n = 0;
    while (fault_out_n !== 1'b1 && n < 1000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 1000)
    begin
      n_fail++;
      end_sim();
    end
    chk_bit(n >= 99 * TICK - 4 && n <= 100 * TICK + 4, 1'b1);
  endtask : t_irq_modes

  // Mid-run reset must drop a held fault and the protection register setting
  task automatic t_rerst;
    wr(ADDR_LOCK_CFG, 32'h00000000);
    wr(ADDR_PROT_CFG, 32'h04000000);
    meas(12'h7d0, 12'h1f4, 12'h1f4, 1'b0);
    chk_bit(fault_out_n, 1'b0);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_bit(fault_out_n, 1'b1);
    chk_bit(irq, 1'b0);
    rd(ADDR_PROT_CFG, v);
    chk_word(v, 32'h00000000);
    rd(ADDR_ACTIVE, v);
    chk_word(v, 32'h00000000);
  endtask : t_rerst

  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_ospd();
    t_hall_load();
    t_uv();
    t_ov();
    t_irq_modes();
    t_rerst();
    end_sim();
  end
endmodule : tb
